// file: core/ubm_mul_array.sv
// Purpose: Combinational unsigned byte product
// Assumes: Operands are plain magnitudes
// Notes:   Shift-add form, maps to one multiplier in synthesis
`timescale 1ns/1ps
`include "ubm_regs.svh"
module ubm_mul_array (
	ubm_mul_if.array mif
);
	////////////////////////////////////////////////////////////////////////////
	// Zero-extended partial products only; no sign handling at all
	always_comb begin
		ubm_pkg::ubm_prod_t acc; // Running sum
		acc = '0;
		for (int i = 0; i < `UBM_OPND_W; i++) begin
			// Add shifted operand when multiplier bit set
			if (mif.opnd_b[i]) begin
				acc = acc + (ubm_pkg::ubm_prod_t'(mif.opnd_a) << i); // RQ1
			end
		end
		mif.product = acc;
	end
endmodule

// file: core/ubm_mul_if.sv
// Purpose: Carrier between the multiplier top and its array
// Assumes: Same clock on both sides
// Notes:   Purely combinational payload
`timescale 1ns/1ps
interface ubm_mul_if;
	ubm_pkg::ubm_byte_t opnd_a;  // Working register operand
	ubm_pkg::ubm_byte_t opnd_b;  // File operand
	ubm_pkg::ubm_prod_t product; // Unsigned product
	modport master (output opnd_a, output opnd_b, input product);
	modport array (input opnd_a, input opnd_b, output product);
endinterface

// file: core/ubm_multiplier.sv
// Purpose: Unsigned 8x8 multiplier with product register pair
// Assumes: Core issues requests synchronous to CLK_SYS
// Notes:   Result visible one edge after issue
// Function
// RQ1: Operands are unsigned, never sign extended
// RQ2: High byte to high reg, low to low
// RQ3: Multiply never changes status flags
// RQ4: Product ready for the next instruction
// RQ5: Operands are working register and file byte
// RQ6: Software corrects high byte for signed results
// RQ7: Product holds until multiply or direct write
`timescale 1ns/1ps
`include "ubm_regs.svh"
module ubm_multiplier (
	input  wire logic                   CLK_SYS,
	input  wire logic                   RST_N,
	input  wire logic                   MUL_ISSUE,
	input  wire ubm_pkg::ubm_byte_t     WORK_REG,
	input  wire ubm_pkg::ubm_byte_t     FILE_OPND,
	input  wire logic                   PROD_HI_WE,
	input  wire logic                   PROD_LO_WE,
	input  wire ubm_pkg::ubm_byte_t     PROD_WDATA,
	input  wire logic [4:0]             STATUS_IN,
	input  wire logic                   STATUS_WE,
	output ubm_pkg::ubm_byte_t          PRODUCT_HIGH,
	output ubm_pkg::ubm_byte_t          PRODUCT_LOW,
	output logic [4:0]                  STATUS_OUT,
	output logic                        MUL_DONE
);
	////////////////////////////////////////////////////////////////////////////
	// Signals
	ubm_mul_if             mif ();            // Array carrier
	ubm_pkg::ubm_byte_t    product_high_reg;  // Upper product byte
	ubm_pkg::ubm_byte_t    product_low_reg;   // Lower product byte
	logic [4:0]            status_reg;        // Core flags
	logic                  done_reg;          // Completion pulse
	ubm_pkg::ubm_src_e     hi_src;            // High byte source
	ubm_pkg::ubm_src_e     lo_src;            // Low byte source

	////////////////////////////////////////////////////////////////////////////
	// Operand routing: working register times file operand
	assign mif.opnd_a = WORK_REG;  // RQ5
	assign mif.opnd_b = FILE_OPND; // RQ5

	ubm_mul_array u_array (
		.mif (mif.array)
	);

	////////////////////////////////////////////////////////////////////////////
	// Source select; multiply wins over a same-cycle direct write
	always_comb begin
		if (MUL_ISSUE) begin
			hi_src = ubm_pkg::UBM_SRC_MUL;
			lo_src = ubm_pkg::UBM_SRC_MUL;
		end else begin
			hi_src = PROD_HI_WE ? ubm_pkg::UBM_SRC_WR : ubm_pkg::UBM_SRC_HOLD;
			lo_src = PROD_LO_WE ? ubm_pkg::UBM_SRC_WR : ubm_pkg::UBM_SRC_HOLD;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// High product register
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			product_high_reg <= `UBM_PROD_HI_RST;
		end else begin
			unique case (hi_src)
				ubm_pkg::UBM_SRC_MUL: begin
					product_high_reg <= mif.product[`UBM_HI_MSB:`UBM_HI_LSB]; // RQ2
				end
				ubm_pkg::UBM_SRC_WR: begin
					product_high_reg <= PROD_WDATA; // RQ7
				end
				ubm_pkg::UBM_SRC_HOLD: begin
					product_high_reg <= product_high_reg; // RQ7
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Low product register
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			product_low_reg <= `UBM_PROD_LO_RST;
		end else begin
			unique case (lo_src)
				ubm_pkg::UBM_SRC_MUL: begin
					product_low_reg <= mif.product[`UBM_LO_MSB:`UBM_LO_LSB]; // RQ2
				end
				ubm_pkg::UBM_SRC_WR: begin
					product_low_reg <= PROD_WDATA; // RQ7
				end
				ubm_pkg::UBM_SRC_HOLD: begin
					product_low_reg <= product_low_reg; // RQ7
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Status flags: only the core's own write changes them
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			status_reg <= `UBM_STATUS_RST;
		end else if (STATUS_WE && !MUL_ISSUE) begin
			// A multiply cycle carries no flag update
			status_reg <= STATUS_IN; // RQ3
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Done pulse one edge after issue
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			done_reg <= 1'b0;
		end else begin
			done_reg <= MUL_ISSUE; // RQ4
		end
	end

	// Outputs straight from flops
	assign PRODUCT_HIGH = product_high_reg;
	assign PRODUCT_LOW  = product_low_reg;
	assign STATUS_OUT   = status_reg;
	assign MUL_DONE     = done_reg;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	// Registered pair equals the zero-extended operands multiplied
	property p_unsigned_product;
		@(posedge CLK_SYS) disable iff (!RST_N)
		MUL_ISSUE |=> {product_high_reg, product_low_reg} ==
			(16'($past(WORK_REG)) * 16'($past(FILE_OPND)));
	endproperty
	a_unsigned_product: assert property (p_unsigned_product) // RQ1
		else $error("product is not the unsigned product");

	// Largest operands show where each product byte lands
	property p_high_byte;
		@(posedge CLK_SYS) disable iff (!RST_N)
		(MUL_ISSUE && WORK_REG == 8'hFF && FILE_OPND == 8'hFF) |=>
			(product_high_reg == 8'hFE && product_low_reg == 8'h01);
	endproperty
	a_high_byte: assert property (p_high_byte) // RQ2
		else $error("product bytes placed wrongly");

	// A multiply edge never moves the flags
	property p_flags_kept;
		@(posedge CLK_SYS) disable iff (!RST_N)
		MUL_ISSUE |=> $stable(status_reg);
	endproperty
	a_flags_kept: assert property (p_flags_kept) // RQ3
		else $error("multiply changed flags");

	// Low product byte and done pulse both present one edge after issue
	property p_one_cycle;
		@(posedge CLK_SYS) disable iff (!RST_N)
		MUL_ISSUE |=> MUL_DONE ##0 (product_low_reg == 8'($past(WORK_REG) * $past(FILE_OPND)));
	endproperty
	a_one_cycle: assert property (p_one_cycle) // RQ4
		else $error("product not ready after one cycle");

	// Unit file operand passes the working register straight through
	property p_operand_route;
		@(posedge CLK_SYS) disable iff (!RST_N)
		(MUL_ISSUE && FILE_OPND == 8'h01) |=> product_low_reg == $past(WORK_REG);
	endproperty
	a_operand_route: assert property (p_operand_route) // RQ5
		else $error("working register not used as operand");

	// Nothing asked, nothing changes
	property p_hold;
		@(posedge CLK_SYS) disable iff (!RST_N)
		(!MUL_ISSUE && !PROD_HI_WE && !PROD_LO_WE) |=>
			$stable(product_high_reg) && $stable(product_low_reg);
	endproperty
	a_hold: assert property (p_hold) // RQ7
		else $error("product changed without cause");

	// Direct write to the high byte outside a multiply
	property p_direct_write;
		@(posedge CLK_SYS) disable iff (!RST_N)
		(!MUL_ISSUE && PROD_HI_WE) |=> product_high_reg == $past(PROD_WDATA);
	endproperty
	a_direct_write: assert property (p_direct_write) // RQ7
		else $error("direct write to high product lost");

	// Done never appears without a multiply behind it
	property p_done_only_after_issue;
		@(posedge CLK_SYS) disable iff (!RST_N)
		!MUL_ISSUE |=> !MUL_DONE;
	endproperty
	a_done_only_after_issue: assert property (p_done_only_after_issue) // RQ4
		else $error("done without issue");

	// Both operands high: an unsigned reading keeps the top byte large
	property p_high_unsigned;
		@(posedge CLK_SYS) disable iff (!RST_N)
		(MUL_ISSUE && WORK_REG[7] && FILE_OPND[7]) |=> product_high_reg >= 8'h40;
	endproperty
	a_high_unsigned: assert property (p_high_unsigned) // RQ1
		else $error("top byte too small for unsigned operands");

	// Core flag write outside a multiply lands unchanged
	property p_status_write;
		@(posedge CLK_SYS) disable iff (!RST_N)
		(STATUS_WE && !MUL_ISSUE) |=> status_reg == $past(STATUS_IN);
	endproperty
	a_status_write: assert property (p_status_write) // RQ3
		else $error("flag write lost");

	// Direct write to the low byte outside a multiply
	property p_direct_write_low;
		@(posedge CLK_SYS) disable iff (!RST_N)
		(!MUL_ISSUE && PROD_LO_WE) |=> product_low_reg == $past(PROD_WDATA);
	endproperty
	a_direct_write_low: assert property (p_direct_write_low) // RQ7
		else $error("direct write to low product lost");

	// A low-only write must leave the high byte alone
	property p_high_kept_on_low_write;
		@(posedge CLK_SYS) disable iff (!RST_N)
		(!MUL_ISSUE && !PROD_HI_WE && PROD_LO_WE) |=> $stable(product_high_reg);
	endproperty
	a_high_kept_on_low_write: assert property (p_high_kept_on_low_write) // RQ7
		else $error("high product moved on a low write");
endmodule

// file: core/ubm_pkg.sv
// Purpose: Types shared by the byte multiplier files
// Assumes: Constants header supplies the widths
// Notes:   Nothing is imported anywhere
`include "ubm_regs.svh"
package ubm_pkg;
	// One operand byte
	typedef logic [`UBM_OPND_W-1:0] ubm_byte_t;
	// Full product
	typedef logic [`UBM_PROD_W-1:0] ubm_prod_t;
	// Source of a product register update
	typedef enum logic [1:0] {
		UBM_SRC_HOLD,
		UBM_SRC_MUL,
		UBM_SRC_WR
	} ubm_src_e;
endpackage

// file: core/ubm_regs.svh
// Purpose: Constants for the byte multiplier block
// Assumes: Included by bare name from design files
// Notes:   Definitions only
`ifndef UBM_REGS_SVH
`define UBM_REGS_SVH

// Operand and product widths
`define UBM_OPND_W      8
`define UBM_PROD_W      16
// Field positions of the product
`define UBM_HI_MSB      15
`define UBM_HI_LSB      8
`define UBM_LO_MSB      7
`define UBM_LO_LSB      0
// Reset values of the product registers
`define UBM_PROD_HI_RST 8'h00
`define UBM_PROD_LO_RST 8'h00
// Reset value of the stand-in flag register
`define UBM_STATUS_RST  5'h00
// Cycles from issue to readable product
`define UBM_LAT_CYC     1

`endif

// file: testbench/tb_top.sv
// Purpose: Self-checking bench for the byte multiplier
// Assumes: Inputs change on rising edges, results read 1 ns later
// Notes:   One task per scenario
`timescale 1ns/1ps
module tb_top;
	logic               CLK_SYS, RST_N, MUL_ISSUE;                // Clock, reset, request
	ubm_pkg::ubm_byte_t WORK_REG, FILE_OPND, PROD_WDATA;         // Operands, write data
	logic               PROD_HI_WE, PROD_LO_WE, STATUS_WE;       // Write strobes
	logic [4:0]         STATUS_IN, STATUS_OUT;                   // Flag stand-in
	ubm_pkg::ubm_byte_t PRODUCT_HIGH, PRODUCT_LOW;               // Product pair
	logic               MUL_DONE;                                // Done pulse
	ubm_pkg::ubm_byte_t sa, sb;                                  // Signed arguments
	ubm_pkg::ubm_prod_t sprod;                                   // Corrected product
	int                 num_errors = 0, num_checks = 0, cycles = 0; // Bookkeeping

	ubm_multiplier ubm_multiplier_inst (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .MUL_ISSUE(MUL_ISSUE),
		.WORK_REG(WORK_REG), .FILE_OPND(FILE_OPND), .PROD_HI_WE(PROD_HI_WE), .PROD_LO_WE(PROD_LO_WE),
		.PROD_WDATA(PROD_WDATA), .STATUS_IN(STATUS_IN), .STATUS_WE(STATUS_WE),
		.PRODUCT_HIGH(PRODUCT_HIGH), .PRODUCT_LOW(PRODUCT_LOW), .STATUS_OUT(STATUS_OUT), .MUL_DONE(MUL_DONE));
	ubm_core_model ubm_core_model_inst (.arg_a(sa), .arg_b(sb), .prod_hi(PRODUCT_HIGH),
		.prod_lo(PRODUCT_LOW), .signed_prod(sprod));

	////////////////////////////////////////////////////////////////////////////
	// 200 MHz clock
	initial begin
		CLK_SYS = 1'b0;
		forever #2.5 CLK_SYS = ~CLK_SYS;
	end

	// Hang guard, far above the roughly 50 cycles the run needs
	always @(posedge CLK_SYS) begin
		cycles <= cycles + 1;
		if (cycles == 1000) begin
			num_errors++;
			summarize();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One cycle of stimulus; results of the previous cycle are settled on return
	task automatic step(input logic [7:0] a, b, input logic go, hwe, lwe, input logic [7:0] wd,
		input logic swe, input logic [4:0] si);
		@(posedge CLK_SYS);
		WORK_REG <= a;
		FILE_OPND <= b;
		MUL_ISSUE <= go;
		PROD_HI_WE <= hwe;
		PROD_LO_WE <= lwe;
		PROD_WDATA <= wd;
		STATUS_WE <= swe;
		STATUS_IN <= si;
		#1;
	endtask

	task automatic mul(input logic [7:0] a, b);
		step(a, b, 1'b1, 1'b0, 1'b0, 8'h00, 1'b0, 5'h00);
	endtask

	// Idle with busy operands so a stale product cannot hide
	task automatic idle;
		step(8'h5A, 8'hC3, 1'b0, 1'b0, 1'b0, 8'h00, 1'b0, 5'h00);
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic t_walk;
		mul(8'hFF, 8'hFF);
		idle();
		chk({PRODUCT_HIGH, PRODUCT_LOW}, 16'hFE01);
		chk({15'h0000, MUL_DONE}, 16'h0001);
		idle();
		chk({15'h0000, MUL_DONE}, 16'h0000);
		chk({PRODUCT_HIGH, PRODUCT_LOW}, 16'hFE01);
	endtask

	// Back to back, operands picked so a signed reading would differ except for 80h times 80h; last one has a unit file operand
	task automatic t_back;
		logic [7:0] av [5] = '{8'h80, 8'h01, 8'h7F, 8'hFF, 8'hC9};
		logic [7:0] bv [5] = '{8'h80, 8'hFF, 8'h81, 8'h02, 8'h01};
		for (int i = 0; i < 6; i++) begin
			if (i < 5) mul(av[i], bv[i]);
			else idle();
			if (i > 0) begin
				chk({PRODUCT_HIGH, PRODUCT_LOW}, 16'(av[i-1]) * 16'(bv[i-1]));
				chk({15'h0000, MUL_DONE}, 16'h0001);
			end
		end
	endtask

	// Flag write and direct writes that collide with a multiply are lost
	task automatic t_flags;
		step(8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00, 1'b1, 5'h15);
		step(8'h03, 8'h07, 1'b1, 1'b1, 1'b1, 8'h55, 1'b1, 5'h0A);
		idle();
		chk({11'h000, STATUS_OUT}, 16'h0015);
		chk({PRODUCT_HIGH, PRODUCT_LOW}, 16'h0015);
	endtask

	task automatic t_hold;
		step(8'h5A, 8'hC3, 1'b0, 1'b1, 1'b0, 8'hA5, 1'b0, 5'h00);
		step(8'h5A, 8'hC3, 1'b0, 1'b0, 1'b1, 8'h3C, 1'b0, 5'h00);
		idle();
		chk({PRODUCT_HIGH, PRODUCT_LOW}, 16'hA53C);
		repeat (3) idle();
		chk({PRODUCT_HIGH, PRODUCT_LOW}, 16'hA53C);
	endtask

	// Minus three times five through the core's correction
	task automatic t_signed;
		sa = 8'hFD;
		sb = 8'h05;
		mul(sa, sb);
		idle();
		chk(sprod, 16'hFFF1);
		// Minus three times minus five needs both corrections
		sa = 8'hFD;
		sb = 8'hFB;
		mul(sa, sb);
		idle();
		chk(sprod, 16'h000F);
	endtask

	// Reset in mid-run clears a live product, then a request at the first edge after release
	task automatic t_reset;
		mul(8'h12, 8'h34);
		@(posedge CLK_SYS);
		RST_N <= 1'b0;
		MUL_ISSUE <= 1'b0;
		#1;
		chk({PRODUCT_HIGH, PRODUCT_LOW}, 16'h0000);
		chk({10'h000, STATUS_OUT, MUL_DONE}, 16'h0000);
		repeat (2) @(posedge CLK_SYS);
		RST_N <= 1'b1;
		WORK_REG <= 8'h0B;
		FILE_OPND <= 8'h0D;
		MUL_ISSUE <= 1'b1;
		idle();
		chk({PRODUCT_HIGH, PRODUCT_LOW}, 16'h008F);
		chk({15'h0000, MUL_DONE}, 16'h0001);
	endtask

	task automatic summarize;
		if (num_errors == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		{MUL_ISSUE, PROD_HI_WE, PROD_LO_WE, STATUS_WE} = 4'h0;
		{WORK_REG, FILE_OPND, PROD_WDATA} = 24'h000000;
		STATUS_IN = 5'h00;
		{sa, sb} = 16'h0000;
		RST_N = 1'b0;
		repeat (19) @(posedge CLK_SYS);
		#1;
		chk({PRODUCT_HIGH, PRODUCT_LOW}, 16'h0000);
		chk({10'h000, STATUS_OUT, MUL_DONE}, 16'h0000);
		@(posedge CLK_SYS);
		RST_N <= 1'b1;
		t_walk();
		t_back();
		t_flags();
		t_hold();
		t_reset();
		t_signed();
		summarize();
	end
endmodule

// file: testbench/ubm_core_model.sv
// Purpose: Core-side model that turns the unsigned product into a signed one
// Assumes: Product bytes come straight from the multiplier registers
// Notes:   Behavioural and combinational, stands in for the correction code
`timescale 1ns/1ps
module ubm_core_model (
	input  wire ubm_pkg::ubm_byte_t arg_a,      // Working register argument
	input  wire ubm_pkg::ubm_byte_t arg_b,      // File argument
	input  wire ubm_pkg::ubm_byte_t prod_hi,    // Unsigned high byte
	input  wire ubm_pkg::ubm_byte_t prod_lo,    // Unsigned low byte
	output ubm_pkg::ubm_prod_t      signed_prod // Two's complement product
);
	ubm_pkg::ubm_byte_t hi_fix; // High byte after the subtractions

	////////////////////////////////////////////////////////////////////////////
	// Low byte needs no fix; only the high byte carries the sign error
	always_comb begin
		hi_fix = prod_hi;
		// Negative file argument: take away the working one
		if (arg_b[7]) hi_fix = hi_fix - arg_a;
		// Negative working argument: take away the file one
		if (arg_a[7]) hi_fix = hi_fix - arg_b;
	end
	assign signed_prod = {hi_fix, prod_lo};
endmodule
